// *** shared/dhbgc_defs.svh ***
`ifndef DHBGC_DEFS_SVH
`define DHBGC_DEFS_SVH

// ==========================================================
// Register addresses on the serial port
`define DHBGC_ADDR_CTRL1 7'h01
`define DHBGC_ADDR_CTRL10 7'h0a
`define DHBGC_ADDR_CTRL21 7'h15
`define DHBGC_ADDR_CONFIG 7'h20
`define DHBGC_ADDR_STATUS 7'h30

// ==========================================================
// Reset values
`define DHBGC_RST_REG 8'h00
`define DHBGC_RST_FLAGS 6'h00

// ==========================================================
// Field positions
`define DHBGC_CTRL1_EN_LSB 0
`define DHBGC_CFG_DUAL_LSB 0
`define DHBGC_CFG_DIR_LSB 2
`define DHBGC_C21_DS_LSB 0
`define DHBGC_C21_DEAD_LSB 3
`define DHBGC_C21_SLEW_LSB 6
`define DHBGC_FLT_PUMP 0
`define DHBGC_FLT_OVER 1
`define DHBGC_FLT_UNDER 2
`define DHBGC_FLT_DS 3
`define DHBGC_FLT_THERM 4
`define DHBGC_FLT_WDG 5

// ==========================================================
// Sizes and frame counts
`define DHBGC_LEGS 4
`define DHBGC_FAULTS 6
`define DHBGC_ADDR_DONE 5'h07
`define DHBGC_ADDR_BITS 5'h08
`define DHBGC_FRAME_BITS 5'h10

`endif

// *** shared/dhbgc_pkg.sv ***
package dhbgc_pkg;

    // Gate pair command: {high, low}
    typedef enum logic [1:0] {
        DHBGC_GATE_OFF = 2'b00,
        DHBGC_GATE_LS = 2'b01,
        DHBGC_GATE_HS = 2'b10
    } dhbgc_gate_t;

endpackage

// *** src/dhbgc_spi_slave.sv ***
`timescale 1ns/1ps
`include "dhbgc_defs.svh"

// 16-bit frames, mode 0, MSB first: write flag, 7-bit address, 8 data bits
module dhbgc_spi_slave import dhbgc_pkg::*; (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic sclk_i,
    input wire logic cs_n_i,
    input wire logic mosi_i,
    output logic miso_o,
    output logic miso_oe_o,
    output logic wr_pulse_o,
    output logic [6:0] addr_o,
    output logic [7:0] wr_data_o,
    input wire logic [7:0] rd_data_i
);
    logic sclk_q;
    logic cs_q;
    logic [4:0] cnt;
    logic [15:0] shift_in;
    logic [7:0] shift_out;
    logic wr_flag;
    logic rise;
    logic fall;
    logic cs_end;

    assign rise = sclk_i & ~sclk_q & ~cs_n_i;
    assign fall = ~sclk_i & sclk_q & ~cs_n_i;
    assign cs_end = cs_n_i & ~cs_q;
    assign miso_o = shift_out[7];
    assign miso_oe_o = ~cs_n_i;

    // ==========================================================
    // Edge detection
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            sclk_q <= 1'b0;
            cs_q <= 1'b1;
        end else begin
            sclk_q <= sclk_i;
            cs_q <= cs_n_i;
        end
    end

    // ==========================================================
    // Receive shifter, address capture
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            cnt <= 5'h00;
            shift_in <= 16'h0000;
            addr_o <= 7'h00;
            wr_flag <= 1'b0;
        end else if (cs_n_i) begin
            cnt <= 5'h00;
        end else if (rise && cnt != `DHBGC_FRAME_BITS) begin
            shift_in <= {shift_in[14:0], mosi_i};
            cnt <= cnt + 5'h01;
            if (cnt == `DHBGC_ADDR_DONE) begin
                addr_o <= {shift_in[5:0], mosi_i};
                wr_flag <= shift_in[6];
            end
        end
    end

    // ==========================================================
    // Read data shifter, changes on falling clock
    always_ff @(posedge clk_i) begin
        if (!rst_n_i || cs_n_i) begin
            shift_out <= 8'h00;
        end else if (fall && cnt == `DHBGC_ADDR_BITS) begin
            shift_out <= rd_data_i;
        end else if (fall && cnt > `DHBGC_ADDR_BITS) begin
            shift_out <= {shift_out[6:0], 1'b0};
        end
    end

    // ==========================================================
    // Commit a full write frame when chip select rises
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            wr_pulse_o <= 1'b0;
            wr_data_o <= 8'h00;
        end else begin
            wr_pulse_o <= cs_end && cnt == `DHBGC_FRAME_BITS && wr_flag;
            if (cs_end && cnt == `DHBGC_FRAME_BITS) begin
                wr_data_o <= shift_in[7:0];
            end
        end
    end

    a_write_needs_frame: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        wr_pulse_o |-> $past(cnt) == `DHBGC_FRAME_BITS && $past(cs_end))
        else $error("write committed without a full frame");
endmodule

// *** src/dhbgc_gate_ctrl.sv ***
`timescale 1ns/1ps
`include "dhbgc_defs.svh"

module dhbgc_gate_ctrl import dhbgc_pkg::*; (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic spi_sclk_i,
    input wire logic spi_cs_n_i,
    input wire logic spi_mosi_i,
    output logic spi_miso_o,
    output logic spi_miso_oe_o,
    input wire logic [3:0] leg_pwm_input_i,
    input wire logic pump_low_fault_i,
    input wire logic supply_over_fault_i,
    input wire logic supply_under_fault_i,
    input wire logic drain_source_fault_i,
    input wire logic thermal_stop_level1_i,
    input wire logic watchdog_fault_i,
    output logic [3:0] high_gate_out_o,
    output logic [3:0] low_gate_out_o,
    output logic [5:0] fault_flags_o,
    output logic [2:0] ds_monitor_cfg_o,
    output logic [2:0] dead_time_cfg_o,
    output logic [1:0] slew_rate_cfg_o
);
    logic wr_pulse;
    logic [6:0] addr;
    logic [7:0] wr_data;
    logic [7:0] rd_data;
    logic [7:0] ctrl1;
    logic [7:0] config_reg;
    logic [7:0] ctrl10;
    logic [7:0] ctrl21;
    logic [5:0] fault_flags;
    logic [5:0] fault_vec;
    logic fault_any;
    logic [1:0] bridge_a_b_enable;
    logic [1:0] bridge_dual_setting;
    logic [1:0] bridge_direction_bit;

    function automatic dhbgc_gate_t leg_decode(input logic pwm, input logic sel,
                                               input logic flt);
        dhbgc_gate_t g;
        g = DHBGC_GATE_OFF;
        if (flt) begin
            if (pwm) begin
                g = sel ? DHBGC_GATE_LS : DHBGC_GATE_HS;
            end
        end else begin
            g = (pwm ^ sel) ? DHBGC_GATE_HS : DHBGC_GATE_LS;
        end
        return g;
    endfunction

    // ==========================================================
    // Serial port
    dhbgc_spi_slave u_spi (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .sclk_i(spi_sclk_i),
        .cs_n_i(spi_cs_n_i),
        .mosi_i(spi_mosi_i),
        .miso_o(spi_miso_o),
        .miso_oe_o(spi_miso_oe_o),
        .wr_pulse_o(wr_pulse),
        .addr_o(addr),
        .wr_data_o(wr_data),
        .rd_data_i(rd_data)
    );

    // ==========================================================
    // Register writes
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            ctrl1 <= `DHBGC_RST_REG;
            config_reg <= `DHBGC_RST_REG;
            ctrl10 <= `DHBGC_RST_REG;
            ctrl21 <= `DHBGC_RST_REG;
        end else if (wr_pulse) begin
            unique case (addr)
                `DHBGC_ADDR_CTRL1: ctrl1 <= wr_data;
                `DHBGC_ADDR_CONFIG: config_reg <= wr_data;
                `DHBGC_ADDR_CTRL10: ctrl10 <= wr_data;
                `DHBGC_ADDR_CTRL21: ctrl21 <= wr_data;
                default: ;
            endcase
        end
    end

    // ==========================================================
    // Register reads, unmapped addresses read zero
    always_comb begin
        unique case (addr)
            `DHBGC_ADDR_CTRL1: rd_data = ctrl1;
            `DHBGC_ADDR_CONFIG: rd_data = config_reg;
            `DHBGC_ADDR_CTRL10: rd_data = ctrl10;
            `DHBGC_ADDR_CTRL21: rd_data = ctrl21;
            `DHBGC_ADDR_STATUS: rd_data = {2'b00, fault_flags};
            default: rd_data = 8'h00;
        endcase
    end

    assign bridge_a_b_enable = ctrl1[`DHBGC_CTRL1_EN_LSB +: 2];
    assign bridge_dual_setting = config_reg[`DHBGC_CFG_DUAL_LSB +: 2];
    assign bridge_direction_bit = config_reg[`DHBGC_CFG_DIR_LSB +: 2];
    assign ds_monitor_cfg_o = ctrl21[`DHBGC_C21_DS_LSB +: 3];
    assign dead_time_cfg_o = ctrl21[`DHBGC_C21_DEAD_LSB +: 3];
    assign slew_rate_cfg_o = ctrl21[`DHBGC_C21_SLEW_LSB +: 2];

    // ==========================================================
    // Fault flags: sticky, write one to clear, a new fault wins
    always_comb begin
        fault_vec = 6'h00;
        fault_vec[`DHBGC_FLT_PUMP] = pump_low_fault_i;
        fault_vec[`DHBGC_FLT_OVER] = supply_over_fault_i;
        fault_vec[`DHBGC_FLT_UNDER] = supply_under_fault_i;
        fault_vec[`DHBGC_FLT_DS] = drain_source_fault_i;
        fault_vec[`DHBGC_FLT_THERM] = thermal_stop_level1_i;
        fault_vec[`DHBGC_FLT_WDG] = watchdog_fault_i;
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            fault_flags <= `DHBGC_RST_FLAGS;
        end else if (wr_pulse && addr == `DHBGC_ADDR_STATUS) begin
            fault_flags <= (fault_flags & ~wr_data[5:0]) | fault_vec;
        end else begin
            fault_flags <= fault_flags | fault_vec;
        end
    end

    assign fault_any = |fault_flags || |fault_vec;
    assign fault_flags_o = fault_flags;

    a_flag_set_wins: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        watchdog_fault_i |=> fault_flags[`DHBGC_FLT_WDG])
        else $error("watchdog fault not latched");

    a_flag_holds: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        fault_flags[`DHBGC_FLT_PUMP] && !(wr_pulse && addr == `DHBGC_ADDR_STATUS)
        |=> fault_flags[`DHBGC_FLT_PUMP])
        else $error("fault flag dropped without a clear");

    // ==========================================================
    // Per-leg gate drive: leg 0..3 = 1A, 2A, 1B, 2B
    for (genvar i = 0; i < `DHBGC_LEGS; i++) begin : g_leg
        localparam int B = i / 2;
        logic leg_ok;
        dhbgc_gate_t cmd;

        assign leg_ok = bridge_a_b_enable[B] && bridge_dual_setting[B] && !fault_any;
        assign cmd = leg_decode(leg_pwm_input_i[i], ctrl10[2 * i + 1], ctrl10[2 * i]);

        // Both gates of a leg come from one register update
        always_ff @(posedge clk_i) begin
            if (!rst_n_i || !leg_ok) begin
                high_gate_out_o[i] <= 1'b0;
                low_gate_out_o[i] <= 1'b0;
            end else begin
                high_gate_out_o[i] <= cmd[1];
                low_gate_out_o[i] <= cmd[0];
            end
        end

        a_no_shoot_through: assert property (@(posedge clk_i) disable iff (!rst_n_i)
            !(high_gate_out_o[i] && low_gate_out_o[i]))
            else $error("both gates of a leg on");

        a_reset_gates_off: assert property (@(posedge clk_i)
            !rst_n_i |=> !high_gate_out_o[i] && !low_gate_out_o[i])
            else $error("gate on after reset");

        a_fault_gates_off: assert property (@(posedge clk_i) disable iff (!rst_n_i)
            fault_any |=> !high_gate_out_o[i] && !low_gate_out_o[i])
            else $error("gate on during fault");

        a_disabled_off: assert property (@(posedge clk_i) disable iff (!rst_n_i)
            !(bridge_a_b_enable[B] && bridge_dual_setting[B])
            |=> !high_gate_out_o[i] && !low_gate_out_o[i])
            else $error("gate on while bridge disabled or not dual");

        a_drive_high_side: assert property (@(posedge clk_i) disable iff (!rst_n_i)
            leg_ok && leg_pwm_input_i[i] && !ctrl10[2 * i + 1]
            |=> high_gate_out_o[i] && !low_gate_out_o[i])
            else $error("high side not driven");

        a_select_inverts: assert property (@(posedge clk_i) disable iff (!rst_n_i)
            leg_ok && !ctrl10[2 * i] && ctrl10[2 * i + 1]
            |=> high_gate_out_o[i] == !$past(leg_pwm_input_i[i])
                && low_gate_out_o[i] == $past(leg_pwm_input_i[i]))
            else $error("select bit did not invert the leg");

        a_float_passive: assert property (@(posedge clk_i) disable iff (!rst_n_i)
            leg_ok && ctrl10[2 * i] && !leg_pwm_input_i[i]
            |=> !high_gate_out_o[i] && !low_gate_out_o[i])
            else $error("floating leg not off");

        a_float_low_side: assert property (@(posedge clk_i) disable iff (!rst_n_i)
            leg_ok && ctrl10[2 * i] && ctrl10[2 * i + 1] && leg_pwm_input_i[i]
            |=> low_gate_out_o[i] && !high_gate_out_o[i])
            else $error("float with select did not drive low side");

        a_dir_ignored: assert property (@(posedge clk_i) disable iff (!rst_n_i)
            leg_ok && $changed(bridge_direction_bit[B]) && $stable(ctrl10)
            && $stable(leg_pwm_input_i[i]) && $past(leg_ok)
            |=> $stable(high_gate_out_o[i]) && $stable(low_gate_out_o[i]))
            else $error("direction bit changed a leg gate");
    end
endmodule

// *** bench/dhbgc_host_model.sv ***
`timescale 1ns/1ps
`include "dhbgc_defs.svh"

module dhbgc_host_model (
    input wire logic clk_i,
    input wire logic miso_i,
    output logic sclk_o,
    output logic cs_n_o,
    output logic mosi_o,
    output logic [3:0] pwm_o
);
    initial begin
        sclk_o = 1'b0;
        cs_n_o = 1'b1;
        mosi_o = 1'b0;
        pwm_o = 4'h0;
    end

    // ==========================================================
    // Serial frames, every clock level held three device clocks
    task automatic xfer(input logic [15:0] tx, output logic [7:0] rx);
        rx = 8'h00;
        @(posedge clk_i);
        cs_n_o <= 1'b0;
        for (int b = 15; b >= 0; b--) begin
            mosi_o <= tx[b];
            repeat (3) @(posedge clk_i);
            if (b < 8) rx = {rx[6:0], miso_i};
            sclk_o <= 1'b1;
            repeat (3) @(posedge clk_i);
            sclk_o <= 1'b0;
        end
        repeat (3) @(posedge clk_i);
        cs_n_o <= 1'b1;
        // Idle data line shows no stale bit
        mosi_o <= ~tx[0];
        repeat (3) @(posedge clk_i);
    endtask

    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        logic [7:0] rx;
        xfer({1'b1, a, d}, rx);
    endtask

    task automatic rd(input logic [6:0] a, output logic [7:0] d);
        xfer({1'b0, a, 8'h00}, d);
    endtask

    task automatic drive_pwm(input logic [3:0] p);
        @(posedge clk_i);
        pwm_o <= p;
    endtask

    // ==========================================================
    // Host sequences
    task automatic setup(input logic [7:0] cfg);
        drive_pwm(4'h0);
        wr(`DHBGC_ADDR_CTRL10, 8'h55);
        wr(`DHBGC_ADDR_CTRL1, 8'h03);
        wr(`DHBGC_ADDR_CONFIG, cfg);
    endtask

    task automatic step(input logic [7:0] c, input logic [3:0] p);
        fork
            wr(`DHBGC_ADDR_CTRL10, c);
            begin
                repeat (40) @(posedge clk_i);
                pwm_o <= p;
            end
        join
    endtask

    task automatic clr_flags(input logic [5:0] f);
        wr(`DHBGC_ADDR_STATUS, {2'b00, f});
    endtask

    // ==========================================================
    // Six-step commutation chosen from all three hall levels
    // Illegal hall states leave every leg floating
    task automatic commutate(input logic [2:0] hall, input logic duty,
                             output logic [7:0] code);
        logic [3:0] p;
        code = 8'h55;
        p = 4'h0;
        case (hall)
            3'b001: {code, p} = {8'h18, 2'b00, 1'b1, duty};
            3'b000: {code, p} = {8'h24, 1'b0, 1'b1, 1'b0, duty};
            3'b100: {code, p} = {8'h21, 1'b0, 1'b1, duty, 1'b0};
            3'b110: {code, p} = {8'h12, 2'b00, duty, 1'b1};
            3'b111: {code, p} = {8'h06, 1'b0, duty, 2'b01};
            3'b011: {code, p} = {8'h09, 1'b0, duty, 2'b10};
            default: ;
        endcase
        step(code, p);
    endtask
endmodule

// *** bench/test_dual_half_bridge_gate_control.sv ***
`timescale 1ns/1ps
`include "dhbgc_defs.svh"

module test_dual_half_bridge_gate_control;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [5:0] flt = 6'h00;
    logic sclk, cs_n, mosi, miso;
    logic [3:0] pwm, hg, lg;
    logic [5:0] flags;
    logic [2:0] dsm, dtm;
    logic [1:0] slw;
    logic [7:0] rx;
    logic oe;
    int n_fail = 0;
    int tests_run = 0;
    int cycles = 0;

    always #10 clk_i = ~clk_i;

    dhbgc_host_model i_host (.clk_i(clk_i), .miso_i(miso), .sclk_o(sclk), .cs_n_o(cs_n),
        .mosi_o(mosi), .pwm_o(pwm));

    dhbgc_gate_ctrl i_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .spi_sclk_i(sclk),
        .spi_cs_n_i(cs_n), .spi_mosi_i(mosi), .spi_miso_o(miso), .spi_miso_oe_o(oe),
        .leg_pwm_input_i(pwm), .pump_low_fault_i(flt[0]), .supply_over_fault_i(flt[1]),
        .supply_under_fault_i(flt[2]), .drain_source_fault_i(flt[3]),
        .thermal_stop_level1_i(flt[4]), .watchdog_fault_i(flt[5]), .high_gate_out_o(hg),
        .low_gate_out_o(lg), .fault_flags_o(flags), .ds_monitor_cfg_o(dsm),
        .dead_time_cfg_o(dtm), .slew_rate_cfg_o(slw));

    // ==========================================================
    // Checking
    function automatic logic [1:0] leg_exp(logic p, logic s, logic f);
        if (!f) return (p ^ s) ? 2'b10 : 2'b01;
        return !p ? 2'b00 : (s ? 2'b01 : 2'b10);
    endfunction

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk_legs(input logic [7:0] c, input logic [1:0] on);
        logic [3:0] eh, el;
        logic [1:0] g;
        for (int i = 0; i < 4; i++) begin
            g = on[i/2] ? leg_exp(pwm[i], c[2*i+1], c[2*i]) : 2'b00;
            eh[i] = g[1];
            el[i] = g[0];
        end
        chk("high gates", {4'h0, eh}, {4'h0, hg});
        chk("low gates", {4'h0, el}, {4'h0, lg});
        chk("gate overlap", 8'h00, {4'h0, hg & lg});
    endtask

    // ==========================================================
    // Scenarios
    task automatic t_reset;
        chk("gates after reset", 8'h00, {hg, lg});
        chk("flags after reset", 8'h00, {2'b00, flags});
        chk("settings after reset", 8'h00, {dsm, dtm, slw});
        i_host.drive_pwm(4'hf);
        repeat (2) @(posedge clk_i);
        chk("gates before enable", 8'h00, {hg, lg});
        $display("test reset done");
    endtask

    task automatic t_table;
        logic [7:0] c;
        for (int d = 0; d < 2; d++) begin
            i_host.setup(d ? 8'h0f : 8'h03);
            for (int s = 0; s < 4; s++) begin
                c = {2'(s + 3), 2'(s + 2), 2'(s + 1), 2'(s)};
                i_host.wr(`DHBGC_ADDR_CTRL10, c);
                for (int p = 0; p < 16; p++) begin
                    i_host.drive_pwm(4'(p));
                    repeat (2) @(posedge clk_i);
                    chk_legs(c, 2'b11);
                end
                i_host.rd(`DHBGC_ADDR_CTRL10, rx);
                chk("control readback", c, rx);
            end
        end
        $display("test truth table done");
    endtask

    task automatic t_bridge;
        i_host.step(8'h00, 4'h6);
        for (int e = 0; e < 4; e++) begin
            i_host.wr(`DHBGC_ADDR_CTRL1, 8'(e));
            repeat (2) @(posedge clk_i);
            chk_legs(8'h00, 2'(e));
        end
        i_host.wr(`DHBGC_ADDR_CONFIG, 8'h01);
        repeat (2) @(posedge clk_i);
        chk_legs(8'h00, 2'b01);
        i_host.wr(`DHBGC_ADDR_CONFIG, 8'h03);
        $display("test bridge enables done");
    endtask

    task automatic t_fault;
        i_host.step(8'h00, 4'h5);
        for (int k = 0; k < 6; k++) begin
            @(posedge clk_i);
            flt <= 6'(1 << k);
            @(posedge clk_i);
            flt <= 6'h00;
            repeat (2) @(posedge clk_i);
            chk("gates in fault", 8'h00, {hg, lg});
            chk("fault flag", 8'(1 << k), {2'b00, flags});
            i_host.rd(`DHBGC_ADDR_STATUS, rx);
            chk("gates while latched", 8'h00, {hg, lg});
            chk("status readback", 8'(1 << k), rx);
            i_host.clr_flags(6'(1 << k));
            repeat (2) @(posedge clk_i);
            chk("flags cleared", 8'h00, {2'b00, flags});
            chk_legs(8'h00, 2'b11);
        end
        $display("test faults done");
    endtask

    task automatic t_cfg;
        logic [7:0] c;
        for (int i = 0; i < 2; i++) begin
            c = i ? 8'h5a : 8'ha5;
            fork
                i_host.wr(`DHBGC_ADDR_CTRL21, c);
                begin
                    repeat (10) @(posedge clk_i);
                    chk("miso enable in frame", 8'h01, {7'h00, oe});
                end
            join
            chk("monitor dead slew", c, {slw, dtm, dsm});
            chk("miso enable idle", 8'h00, {7'h00, oe});
        end
        i_host.rd(7'h02, rx);
        chk("unmapped readback", 8'h00, rx);
        $display("test settings done");
    endtask

    task automatic t_six;
        logic [2:0] hall [6];
        logic [7:0] c;
        hall = '{3'b001, 3'b000, 3'b100, 3'b110, 3'b111, 3'b011};
        for (int s = 0; s < 12; s++) begin
            i_host.commutate(hall[s / 2], 1'(s), c);
            repeat (2) @(posedge clk_i);
            chk_legs(c, 2'b11);
            chk("driven high sides", 8'(s % 2), 8'($countones(hg[2:0])));
            chk("driven low sides", 8'(2 - s % 2), 8'($countones(lg[2:0])));
        end
        i_host.commutate(3'b010, 1'b1, c);
        repeat (2) @(posedge clk_i);
        chk_legs(c, 2'b11);
        $display("test six step done");
    endtask

    task automatic t_rerun;
        i_host.step(8'h00, 4'h5);
        repeat (2) @(posedge clk_i);
        chk_legs(8'h00, 2'b11);
        rst_n_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        chk("gates in reset", 8'h00, {hg, lg});
        chk("settings in reset", 8'h00, {dsm, dtm, slw});
        rst_n_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        chk_legs(8'h00, 2'b00);
        $display("test mid-run reset done");
    endtask

    // ==========================================================
    // Run control
    task automatic summarize;
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            n_fail++;
            summarize;
        end
    end

    initial begin
        repeat (5) @(posedge clk_i);
        rst_n_i <= 1'b1;
        @(posedge clk_i);
        t_reset;
        t_table;
        t_bridge;
        t_fault;
        t_cfg;
        t_six;
        t_rerun;
        summarize;
    end
endmodule
